/* File: rtl/rps_pkg.sv */
// package: pin bundle, states and timing counts for the reader power sequencer
package rps_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned REF_CLOCK_HZ = 24000000;
  localparam int unsigned CLK_HZ = 100000000;

  localparam int unsigned SETTLE_US = 5000;
  localparam int unsigned INIT_US = 10000;
  localparam int unsigned DIS_US = 100;
  localparam int unsigned OFF_US = 50000;
  localparam int unsigned BOOT_REF_CYCLES = 8706;

  // least times, rounded up to whole clock cycles
  localparam int unsigned SETTLE_CYC = (SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INIT_CYC = (INIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DIS_CYC = (DIS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OFF_CYC = (OFF_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam longint unsigned BOOT_CYC_L =
    (longint'(BOOT_REF_CYCLES) * CLK_HZ + REF_CLOCK_HZ - 1) / REF_CLOCK_HZ;
  localparam int unsigned BOOT_CYC = int'(BOOT_CYC_L);

  localparam int unsigned CNT_W = 24;

  typedef enum logic [3:0] {
    S_OFF = 4'h0,
    S_MAIN_ON = 4'h1,
    S_SETTLE = 4'h2,
    S_INIT = 4'h3,
    S_BOOT_HOLD = 4'h4,
    S_WAIT_READY = 4'h5,
    S_RUN = 4'h6,
    S_DIS_WAIT = 4'h7,
    S_DIS_HOLD = 4'h8,
    S_DISABLED = 4'h9,
    S_PREINIT = 4'hA
  } rps_state_type;

  typedef struct packed {
    logic mainSupplyEn;
    logic coreSupplyEn;
    logic refClockRun;
    logic chipEnable;
    logic restartOut;
    logic restartOe;
    logic strapOut;
    logic strapOe;
    logic readyOut;
    logic readyOe;
  } rps_pins_type;

  localparam rps_pins_type PINS_RESET = '{
    mainSupplyEn: 1'b0, coreSupplyEn: 1'b0, refClockRun: 1'b0, chipEnable: 1'b0,
    restartOut: 1'b0, restartOe: 1'b1, strapOut: 1'b0, strapOe: 1'b0,
    readyOut: 1'b0, readyOe: 1'b0};

endpackage : rps_pkg

/* File: rtl/rps_timer.sv */
// down counter that times one sequencer interval
`timescale 1ns/100ps
module rps_timer #(
  parameter int unsigned W = 24
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [W-1:0] loadVal,
  output logic busy
);

  logic [W-1:0] cnt;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cnt <= '0;
      busy <= 1'b0;
    end else if (start) begin
      cnt <= loadVal;
      busy <= 1'b1;
    end else if (busy) begin
      cnt <= cnt - 1'b1;
      busy <= (cnt > {{(W-1){1'b0}}, 1'b1});
    end
  end

endmodule : rps_timer

/* File: rtl/rps_sequencer.sv */
// host side power, enable and restart sequencer for the reader chip
`timescale 1ns/100ps
module rps_sequencer #(
  parameter int unsigned SETTLE_CYCLES = rps_pkg::SETTLE_CYC,
  parameter int unsigned INIT_CYCLES = rps_pkg::INIT_CYC,
  parameter int unsigned DIS_CYCLES = rps_pkg::DIS_CYC,
  parameter int unsigned OFF_CYCLES = rps_pkg::OFF_CYC,
  parameter int unsigned BOOT_CYCLES = rps_pkg::BOOT_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic cmdPowerUp,
  input wire logic cmdPowerDown,
  input wire logic cmdDisable,
  input wire logic cmdEnable,
  input wire logic bootSelect,
  input wire logic restartIn,
  input wire logic readyIn,
  output rps_pkg::rps_pins_type pins,
  output logic [3:0] seqState,
  output logic deviceReady,
  output logic busy
);

  localparam int unsigned W = rps_pkg::CNT_W;

  rps_pkg::rps_state_type state;
  rps_pkg::rps_state_type next_state;
  rps_pkg::rps_pins_type next_pins;
  logic bootLatched;
  logic goPowerOff;
  logic timerStart;
  logic [W-1:0] timerLoad;
  logic timerBusy;
  logic restartSeen;
  logic readyTaken;

  function automatic logic inStartup(input rps_pkg::rps_state_type s);
    inStartup = (s == rps_pkg::S_INIT) || (s == rps_pkg::S_BOOT_HOLD) ||
      (s == rps_pkg::S_WAIT_READY);
  endfunction : inStartup

  rps_timer #(.W(W)) u_timer (
    .mclk(mclk),
    .rst_b(rst_b),
    .start(timerStart),
    .loadVal(timerLoad),
    .busy(timerBusy)
  );

  always_comb begin
    next_state = state;
    timerStart = 1'b0;
    timerLoad = '0;
    case (state)
      rps_pkg::S_OFF: begin
        if (cmdPowerUp && !timerBusy) begin
          next_state = rps_pkg::S_MAIN_ON;
        end
      end
      rps_pkg::S_MAIN_ON: begin
        next_state = rps_pkg::S_SETTLE;
        timerStart = 1'b1;
        timerLoad = W'(SETTLE_CYCLES);
      end
      rps_pkg::S_SETTLE, rps_pkg::S_PREINIT: begin
        if (!timerBusy) begin
          next_state = rps_pkg::S_INIT;
          timerStart = 1'b1;
          timerLoad = W'(INIT_CYCLES);
        end
      end
      rps_pkg::S_INIT: begin
        if (!timerBusy) begin
          next_state = bootLatched ? rps_pkg::S_BOOT_HOLD : rps_pkg::S_WAIT_READY;
          timerStart = bootLatched;
          timerLoad = W'(BOOT_CYCLES);
        end
      end
      rps_pkg::S_BOOT_HOLD: begin
        if (!timerBusy) begin
          next_state = rps_pkg::S_WAIT_READY;
        end
      end
      rps_pkg::S_WAIT_READY, rps_pkg::S_RUN: begin
        if (cmdPowerDown || cmdDisable) begin
          next_state = rps_pkg::S_DIS_WAIT;
          timerStart = 1'b1;
          timerLoad = W'(DIS_CYCLES);
        end else if (state == rps_pkg::S_WAIT_READY && readyTaken) begin
          next_state = rps_pkg::S_RUN;
        end
      end
      rps_pkg::S_DIS_WAIT: begin
        if (!timerBusy) begin
          next_state = goPowerOff ? rps_pkg::S_OFF : rps_pkg::S_DIS_HOLD;
          timerStart = 1'b1;
          timerLoad = W'(OFF_CYCLES);
        end
      end
      rps_pkg::S_DIS_HOLD: begin
        if (!timerBusy) begin
          next_state = rps_pkg::S_DISABLED;
        end
      end
      rps_pkg::S_DISABLED: begin
        if (cmdPowerDown) begin
          next_state = rps_pkg::S_OFF;
          timerStart = 1'b1;
          timerLoad = W'(OFF_CYCLES);
        end else if (cmdEnable) begin
          next_state = rps_pkg::S_PREINIT;
          timerStart = 1'b1;
          timerLoad = W'(SETTLE_CYCLES);
        end
      end
      default: begin
        next_state = rps_pkg::S_OFF;
      end
    endcase
  end

  wire stOff = (state == rps_pkg::S_OFF);
  wire stMainOnly = (state == rps_pkg::S_MAIN_ON);
  wire stClockStopped = (state == rps_pkg::S_DIS_HOLD) || (state == rps_pkg::S_DISABLED);
  // restart stays released through the enable-low interval and falls on entering DIS_HOLD or OFF
  wire stReleased = (state == rps_pkg::S_BOOT_HOLD) || (state == rps_pkg::S_WAIT_READY) ||
    (state == rps_pkg::S_RUN) || (state == rps_pkg::S_DIS_WAIT);

  always_comb begin
    next_pins = rps_pkg::PINS_RESET;
    next_pins.mainSupplyEn = !stOff;
    next_pins.coreSupplyEn = !stOff && !stMainOnly;
    next_pins.refClockRun = !stOff && !stMainOnly && !stClockStopped;
    next_pins.chipEnable = inStartup(state) || (state == rps_pkg::S_RUN);
    next_pins.restartOut = 1'b0;
    next_pins.restartOe = !stReleased;
    next_pins.strapOut = inStartup(state);
    next_pins.strapOe = inStartup(state);
    next_pins.readyOut = 1'b0;
    next_pins.readyOe = (state == rps_pkg::S_BOOT_HOLD);
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state <= rps_pkg::S_OFF;
      pins <= rps_pkg::PINS_RESET;
      deviceReady <= 1'b0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      pins <= next_pins;
      deviceReady <= (next_state == rps_pkg::S_RUN);
      busy <= (next_state != rps_pkg::S_RUN) && (next_state != rps_pkg::S_OFF) &&
        (next_state != rps_pkg::S_DISABLED);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      bootLatched <= 1'b0;
      goPowerOff <= 1'b0;
    end else begin
      if ((stOff && cmdPowerUp) || (state == rps_pkg::S_DISABLED && cmdEnable)) begin
        bootLatched <= bootSelect;
      end
      if ((state == rps_pkg::S_WAIT_READY) || (state == rps_pkg::S_RUN)) begin
        goPowerOff <= cmdPowerDown;
      end
    end
  end

  // restart line seen low at restartIn while the host has let go
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      restartSeen <= 1'b0;
    end else begin
      restartSeen <= stReleased && !restartIn;
    end
  end

  // ready only counts once our own bootloader pull is gone and restart has risen
  assign readyTaken = !readyIn && !pins.readyOe && !restartSeen;

  assign seqState = state;

  // interval counters that only the checks below read
  localparam int NCNT = 5;
  logic [NCNT-1:0] cntCond;
  logic [W-1:0] gapCnt [NCNT];
  assign cntCond[0] = pins.coreSupplyEn;
  assign cntCond[1] = pins.chipEnable;
  assign cntCond[2] = !pins.chipEnable;
  assign cntCond[3] = !pins.mainSupplyEn;
  assign cntCond[4] = pins.readyOe;

  for (genvar gi = 0; gi < NCNT; gi++) begin : g_gap
    always_ff @(posedge mclk) begin
      if (!rst_b) begin
        gapCnt[gi] <= '1;
      end else if (!cntCond[gi]) begin
        gapCnt[gi] <= '0;
      end else if (gapCnt[gi] != '1) begin
        gapCnt[gi] <= gapCnt[gi] + 1'b1;
      end
    end
  end

  AST_CORE_AFTER_MAIN: assert property (@(posedge mclk) disable iff (!rst_b)
    pins.coreSupplyEn |-> pins.mainSupplyEn)
    else $error("core supply on without main supply");
  AST_CORE_OFF_FIRST: assert property (@(posedge mclk) disable iff (!rst_b)
    $fell(pins.mainSupplyEn) |-> !pins.coreSupplyEn && !pins.chipEnable && !pins.strapOe)
    else $error("main supply dropped before core supply or with pins driven");
  AST_CLOCK_AFTER_POWER: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(pins.refClockRun) |-> pins.mainSupplyEn && pins.coreSupplyEn)
    else $error("reference clock started before supplies");
  AST_INIT_AFTER_SETTLE: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(pins.chipEnable) |-> gapCnt[0] >= W'(SETTLE_CYCLES) && pins.restartOe &&
      pins.strapOe && pins.strapOut && pins.refClockRun)
    else $error("initial pin state applied too early or incomplete");
  AST_RELEASE_AFTER_INIT: assert property (@(posedge mclk) disable iff (!rst_b)
    $fell(pins.restartOe) |-> gapCnt[1] >= W'(INIT_CYCLES))
    else $error("restart released too early");
  AST_STRAP_HELD: assert property (@(posedge mclk) disable iff (!rst_b)
    (pins.chipEnable && !pins.restartOe && !deviceReady && !$past(deviceReady)) |->
      pins.strapOe && pins.strapOut)
    else $error("strap not held high during startup");
  AST_BOOT_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
    $fell(pins.readyOe) |-> gapCnt[4] >= W'(BOOT_CYCLES) && pins.chipEnable)
    else $error("bootloader hold on ready line too short");
  AST_NEVER_HIGH: assert property (@(posedge mclk) disable iff (!rst_b)
    pins.restartOe |-> !pins.restartOut)
    else $error("restart line driven high");
  AST_RUN_PINS: assert property (@(posedge mclk) disable iff (!rst_b)
    deviceReady |-> pins.chipEnable && !pins.restartOe && !pins.readyOe)
    else $error("enable or restart wrong while running");
  AST_RESTART_AFTER_DIS: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(pins.restartOe) |-> gapCnt[2] >= W'(DIS_CYCLES))
    else $error("restart pulled low too soon after enable fell");
  AST_CLOCK_IN_DIS: assert property (@(posedge mclk) disable iff (!rst_b)
    ($fell(pins.chipEnable) && pins.mainSupplyEn) |-> pins.refClockRun [*8])
    else $error("reference clock stopped during disable interval");
  AST_OFF_TIME: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(pins.mainSupplyEn) |-> gapCnt[3] >= W'(OFF_CYCLES))
    else $error("powered up again too soon");

  COV_RUN: cover property (@(posedge mclk) disable iff (!rst_b) $rose(deviceReady));
  COV_BOOT: cover property (@(posedge mclk) disable iff (!rst_b) $fell(pins.readyOe));
  COV_REENABLE: cover property (@(posedge mclk) disable iff (!rst_b)
    state == rps_pkg::S_PREINIT ##1 state == rps_pkg::S_INIT);
  COV_POWER_OFF: cover property (@(posedge mclk) disable iff (!rst_b) $fell(pins.mainSupplyEn));

endmodule : rps_sequencer

/* File: test/rps_device_model.sv */
// behavioural model of the reader chip start-up pins, seen from the host
`timescale 1ns/100ps
module rps_device_model #(
  parameter int REL_CYC = 8,
  parameter int FW_CYC = 12
) (
  input wire logic mclk,
  input wire rps_pkg::rps_pins_type pins,
  input wire logic restartWire,
  output logic restartLow = 1'b0,
  output logic readyLow = 1'b0
);
  logic [1:0] phase = 2'h0;
  int cnt = 0;
  wire live = pins.mainSupplyEn && pins.coreSupplyEn && pins.refClockRun && pins.chipEnable;

  always @(posedge mclk) begin
    if (!live) begin
      phase <= 2'h0;
      cnt <= 0;
      restartLow <= 1'b0;
      readyLow <= 1'b0;
    end else begin
      case (phase)
        2'h0: begin
          restartLow <= 1'b1;
          // start-up only proceeds while the restart line really goes low
          if (restartWire === 1'b0) cnt <= cnt + 1;
          if (cnt >= REL_CYC) begin
            phase <= 2'h1;
            restartLow <= 1'b0;
            cnt <= 0;
          end
        end
        2'h1: if (restartWire === 1'b1) phase <= 2'h2;
        2'h2: begin
          cnt <= cnt + 1;
          if (cnt >= FW_CYC) begin
            readyLow <= 1'b1;
            phase <= 2'h3;
          end
        end
        default: ;
      endcase
    end
  end
endmodule : rps_device_model

/* File: test/rps_sequencer_tb_top.sv */
// self-checking testbench for the reader power sequencer
`timescale 1ns/100ps
module rps_sequencer_tb_top;
  localparam int SET = 20;
  localparam int INI = 40;
  localparam int DIS = 10;
  localparam int OFF = 60;
  localparam int BOOT = 15;
  logic mclk, rst_b, cmdPowerUp, cmdPowerDown, cmdDisable, cmdEnable, bootSelect;
  rps_pkg::rps_pins_type pins;
  logic [3:0] seqState;
  logic deviceReady, busy, devRestartLow, devReadyLow;
  int num_errors = 0;
  int total_checks = 0;
  int held;
  // open-drain lines with pull-ups
  wire restartIn = !(pins.restartOe || devRestartLow);
  wire readyIn = !(pins.readyOe || devReadyLow);

  rps_sequencer #(.SETTLE_CYCLES(SET), .INIT_CYCLES(INI), .DIS_CYCLES(DIS),
    .OFF_CYCLES(OFF), .BOOT_CYCLES(BOOT)) i_dut (.mclk(mclk), .rst_b(rst_b),
    .cmdPowerUp(cmdPowerUp), .cmdPowerDown(cmdPowerDown), .cmdDisable(cmdDisable),
    .cmdEnable(cmdEnable), .bootSelect(bootSelect), .restartIn(restartIn),
    .readyIn(readyIn), .pins(pins), .seqState(seqState), .deviceReady(deviceReady),
    .busy(busy));
  rps_device_model i_dev (.mclk(mclk), .pins(pins), .restartWire(restartIn),
    .restartLow(devRestartLow), .readyLow(devReadyLow));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wrap_up();
    if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  task automatic step();
    @(posedge mclk);
    #1;
  endtask : step

  task automatic wait_state(input logic [3:0] code, output int n);
    n = 0;
    #1;
    while (seqState !== code && n < 5000) begin
      step();
      n++;
    end
    check(16'(seqState), 16'(code));
  endtask : wait_state

  task automatic power_up(input logic boot, output int wait0);
    int n;
    @(posedge mclk);
    cmdPowerUp <= 1'b1;
    bootSelect <= boot;
    wait_state(4'h1, wait0);
    @(posedge mclk);
    cmdPowerUp <= 1'b0;
    wait_state(4'h2, n);
    wait_state(4'h3, n);
    check(16'(n >= SET), 16'h1);
    check(16'({pins.mainSupplyEn, pins.coreSupplyEn, pins.refClockRun}), 16'h7);
    step();
    check(16'({pins.chipEnable, pins.restartOe, pins.strapOe, pins.strapOut, busy}),
      16'h1F);
    wait_state(boot ? 4'h4 : 4'h5, n);
    check(16'(n >= INI), 16'h1);
    step();
    check(16'({pins.restartOe, pins.readyOe}), 16'(boot));
    n = 1;
    while (pins.readyOe === 1'b1 && n < 1000) begin
      step();
      n++;
    end
    if (boot) check(16'(n >= BOOT), 16'h1);
    wait_state(4'h6, n);
    check(16'(n < 200), 16'h1);
    step();
    check(16'({deviceReady, pins.chipEnable, pins.restartOe, busy}), 16'hC);
  endtask : power_up

  task automatic disable_enable();
    int n;
    @(posedge mclk);
    cmdEnable <= 1'b1;
    @(posedge mclk);
    cmdEnable <= 1'b0;
    cmdDisable <= 1'b1;
    @(posedge mclk);
    cmdDisable <= 1'b0;
    wait_state(4'h7, n);
    check(16'(n <= 2), 16'h1);
    step();
    check(16'({pins.chipEnable, pins.restartOe, pins.refClockRun}), 16'h1);
    wait_state(4'h8, n);
    check(16'(n >= DIS), 16'h1);
    step();
    check(16'({pins.restartOe, pins.refClockRun, pins.chipEnable}), 16'h4);
    wait_state(4'h9, n);
    check(16'(n >= OFF), 16'h1);
    check(16'({busy, pins.chipEnable, pins.restartOe}), 16'h1);
    @(posedge mclk);
    cmdEnable <= 1'b1;
    @(posedge mclk);
    cmdEnable <= 1'b0;
    wait_state(4'hA, n);
    wait_state(4'h3, n);
    check(16'(n >= SET), 16'h1);
    step();
    check(16'({pins.chipEnable, pins.restartOe}), 16'h3);
    wait_state(4'h5, n);
    check(16'(n >= INI), 16'h1);
    wait_state(4'h6, n);
  endtask : disable_enable

  task automatic disable_power_down();
    int n;
    @(posedge mclk);
    cmdDisable <= 1'b1;
    @(posedge mclk);
    cmdDisable <= 1'b0;
    wait_state(4'h9, n);
    check(16'({busy, pins.chipEnable, pins.restartOe}), 16'h1);
    @(posedge mclk);
    cmdPowerDown <= 1'b1;
    @(posedge mclk);
    cmdPowerDown <= 1'b0;
    wait_state(4'h0, n);
    check(16'(n <= 2), 16'h1);
    step();
    check(16'({pins.mainSupplyEn, pins.coreSupplyEn, pins.refClockRun,
      pins.restartOe}), 16'h1);
  endtask : disable_power_down

  task automatic power_down();
    int n;
    @(posedge mclk);
    cmdPowerDown <= 1'b1;
    @(posedge mclk);
    cmdPowerDown <= 1'b0;
    wait_state(4'h7, n);
    wait_state(4'h0, n);
    check(16'(n >= DIS), 16'h1);
    step();
    check(16'({pins.mainSupplyEn, pins.coreSupplyEn, pins.refClockRun, pins.chipEnable,
      pins.restartOe}), 16'h1);
  endtask : power_down

  // per-cycle pin hygiene
  always @(negedge mclk) begin
    if (rst_b === 1'b1) begin
      check(16'(pins.coreSupplyEn & ~pins.mainSupplyEn), 16'h0);
      check(16'(pins.refClockRun & ~pins.mainSupplyEn), 16'h0);
      check(16'({pins.restartOut, pins.readyOut}), 16'h0);
      check(16'(seqState == 4'h7 && !pins.refClockRun), 16'h0);
      check(16'((seqState == 4'h4 || seqState == 4'h5) && restartIn &&
        !(pins.strapOe && pins.strapOut)), 16'h0);
    end
  end

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    wrap_up();
  end

  initial begin
    rst_b = 1'b0;
    cmdPowerUp = 1'b0;
    cmdPowerDown = 1'b0;
    cmdDisable = 1'b0;
    cmdEnable = 1'b0;
    bootSelect = 1'b0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    step();
    check(16'(pins), 16'(rps_pkg::PINS_RESET));
    check(16'({seqState, busy, deviceReady}), 16'h0);
    power_up(1'b0, held);
    disable_enable();
    power_down();
    power_up(1'b1, held);
    check(16'(held + 2 >= OFF), 16'h1);
    disable_power_down();
    wrap_up();
  end
endmodule : rps_sequencer_tb_top
